/* core/ocd_top.sv */
// output channel divider and channel 6 output control with apb registers
//
// Register access over APB was chosen for this implementation.
module ocd_top
  import ocd_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // clock sources (asynchronous, synchronised here)
  input  wire logic        synth1_clk_in,
  input  wire logic        synth2_clk_in,
  input  wire logic        priref_clk_in,
  input  wire logic        secref_clk_in,
  // channel 6 output
  output logic             ch6_clk_p_out,
  output logic             ch6_clk_n_out,
  output logic             ch6_p_oe_n_out,
  output logic             ch6_n_oe_n_out,
  output logic [1:0]       ch6_format_out,
  output logic [1:0]       ch6_tail_sel_out,
  output logic [1:0]       ch6_hcsl_load_out,
  output logic             ch6_div_active_out
);
  typedef struct packed {
    // software registers
    logic [7:0]  ch5_div;
    logic [7:0]  ch6_ctl;
    logic        dbl_en;
    // two-flop synchronisers and edge history of the source clocks
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  last;
    // divided output level and bus read latch
    logic        out_lvl;
    logic [31:0] rdata;
  } ocd_state_t;

  ocd_state_t s_q;
  ocd_state_t s_d;

  logic        div_tick;
  logic [1:0]  src_edge;
  logic [1:0]  src_sel;
  logic [1:0]  fmt;
  logic [1:0]  mode_a;
  logic [1:0]  mode_b;
  logic        on_synth;
  logic        src_tick;
  logic        apb_acc;
  logic        wr_en;
  logic        rd_setup;
  logic        hit;
  logic [31:0] rd_word;

  // both cmos pins share one decode: 0 tristate, 1 low, 2 inverted, 3 true
  function automatic logic cmos_level(input logic [1:0] mode, input logic lvl);
    return mode[1] && (lvl ^ !mode[0]);
  endfunction

  function automatic logic cmos_oe_n(input logic [1:0] mode);
    return mode == 2'h0;
  endfunction

  // a doubled reference ticks on both edges, a plain one on rising edges only
  function automatic logic ref_tick(input logic dbl, input logic now, input logic prev);
    return dbl ? (now ^ prev) : (now && !prev);
  endfunction

  // only exact word addresses hit, so a misaligned access answers with an error
  function automatic logic is_mapped(input logic [11:0] addr);
    return addr == OCD_ADDR_CH5_DIV || addr == OCD_ADDR_CH6_CTL ||
           addr == OCD_ADDR_REF_CTL || addr == OCD_ADDR_STATUS;
  endfunction

  assign src_sel  = s_q.ch6_ctl[OCD_SRC_HI:OCD_SRC_LO];
  assign fmt      = s_q.ch6_ctl[OCD_FMT_HI:OCD_FMT_LO];
  assign mode_a   = s_q.ch6_ctl[OCD_MA_HI:OCD_MA_LO];
  assign mode_b   = s_q.ch6_ctl[OCD_MB_HI:OCD_MB_LO];
  assign on_synth = ocd_is_synth(src_sel);
  assign src_edge = s_q.sync2[1:0] & ~s_q.last[1:0];
  assign apb_acc  = psel_in && penable_in;
  assign wr_en    = apb_acc && pwrite_in && pstrb_in[0];
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  assign hit      = is_mapped(paddr_in);

  // doubled reference: tick on both edges when the doubler is enabled
  always_comb begin
    src_tick = 1'b0;
    unique case (src_sel)
      OCD_SRC_SYNTH1: src_tick = src_edge[0];
      OCD_SRC_SYNTH2: src_tick = src_edge[1];
      OCD_SRC_PRIREF: src_tick = ref_tick(s_q.dbl_en, s_q.sync2[2], s_q.last[2]);
      OCD_SRC_SECREF: src_tick = ref_tick(s_q.dbl_en, s_q.sync2[3], s_q.last[3]);
    endcase
  end

  // the channel 6 divider register lies outside this block, so channel 5 setting is the ratio fed here
  // bypass wins over any code, so a reference source never sees the divider
  ocd_divider #(
    .WIDTH (8)
  ) u_div (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .ce_in     (ce_in),
    .tick_in   (src_tick),
    .bypass_in (!on_synth),
    .code_in   (s_q.ch5_div),
    .tick_out  (div_tick)
  );

  always_comb begin
    s_d = s_q;
    // only the second stage feeds edge logic; the first may still be settling
    s_d.sync1 = {secref_clk_in, priref_clk_in, synth2_clk_in, synth1_clk_in};
    s_d.sync2 = s_q.sync1;
    s_d.last  = s_q.sync2;
    // the pin toggles per divided tick, so it runs at half the tick rate
    if (div_tick) begin
      s_d.out_lvl = !s_q.out_lvl;
    end
    // writes need byte lane 0: every register is the low byte of its word
    if (wr_en) begin
      unique case (paddr_in)
        OCD_ADDR_CH5_DIV: s_d.ch5_div = pwdata_in[7:0];
        OCD_ADDR_CH6_CTL: s_d.ch6_ctl = pwdata_in[7:0];
        OCD_ADDR_REF_CTL: s_d.dbl_en  = pwdata_in[OCD_DBL_BIT];
        default: ;
      endcase
    end
    s_d.rdata = 32'h0000_0000;
    if (rd_setup) begin
      s_d.rdata = rd_word;
    end
  end

  // read mux apart from the state update; unmapped addresses read as zero
  // status: bit 2 output level, bit 1 synthesizer source, bit 0 doubler
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr_in)
      OCD_ADDR_CH5_DIV: rd_word = {24'h00_0000, s_q.ch5_div};
      OCD_ADDR_CH6_CTL: rd_word = {24'h00_0000, s_q.ch6_ctl};
      OCD_ADDR_REF_CTL: rd_word = {31'h0, s_q.dbl_en};
      OCD_ADDR_STATUS:  rd_word = {29'h0, s_q.out_lvl, on_synth, s_q.dbl_en};
      default: ;
    endcase
  end

  // reset loads constants only; ce low freezes every field, synchronisers too
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.ch5_div <= OCD_CH5_DIV_RST;
      s_q.ch6_ctl <= OCD_CH6_CTL_RST;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // read data registered in setup phase, so access answers at once
  assign prdata_out  = s_q.rdata;
  // no wait states: every access ends in its first cycle
  assign pready_out  = 1'b1;
  assign pslverr_out = apb_acc && !hit;

  // driver: format gates enables; mode a steers p pin, mode b n pin or hcsl load
  always_comb begin
    ch6_clk_p_out  = 1'b0;
    ch6_clk_n_out  = 1'b0;
    ch6_p_oe_n_out = 1'b1;
    ch6_n_oe_n_out = 1'b1;
    unique case (fmt)
      OCD_FMT_OFF: ;
      OCD_FMT_AC: begin
        ch6_clk_p_out  = s_q.out_lvl;
        ch6_clk_n_out  = !s_q.out_lvl;
        ch6_p_oe_n_out = 1'b0;
        ch6_n_oe_n_out = 1'b0;
      end
      // hcsl leaves n undriven while its load code is tristate
      OCD_FMT_HCSL: begin
        ch6_clk_p_out  = s_q.out_lvl;
        ch6_clk_n_out  = !s_q.out_lvl;
        ch6_p_oe_n_out = 1'b0;
        ch6_n_oe_n_out = (mode_b == 2'h0);
      end
      OCD_FMT_CMOS: begin
        ch6_p_oe_n_out = cmos_oe_n(mode_a);
        ch6_clk_p_out  = cmos_level(mode_a, s_q.out_lvl);
        ch6_n_oe_n_out = cmos_oe_n(mode_b);
        ch6_clk_n_out  = cmos_level(mode_b, s_q.out_lvl);
      end
    endcase
  end

  assign ch6_format_out     = fmt;
  assign ch6_tail_sel_out   = mode_a;
  assign ch6_hcsl_load_out  = (fmt == OCD_FMT_HCSL) ? mode_b : 2'h0;
  assign ch6_div_active_out = on_synth && (s_q.ch5_div != 8'h00);
endmodule

/* core/ocd_pkg.sv */
// package: register map, field layout and encodings of the output channel block
package ocd_pkg;
  // register indexes; the bus sees four bytes per index
  localparam logic [11:0] OCD_IDX_CH5_DIV  = 12'h028;
  localparam logic [11:0] OCD_IDX_CH6_CTL  = 12'h029;
  localparam logic [11:0] OCD_ADDR_CH5_DIV = OCD_IDX_CH5_DIV << 2;
  localparam logic [11:0] OCD_ADDR_CH6_CTL = OCD_IDX_CH6_CTL << 2;
  localparam logic [11:0] OCD_ADDR_REF_CTL = 12'h100;
  localparam logic [11:0] OCD_ADDR_STATUS  = 12'h104;
  localparam logic [7:0] OCD_CH5_DIV_RST = 8'h02;
  localparam logic [7:0] OCD_CH6_CTL_RST = 8'h18;
  localparam int OCD_SRC_HI   = 7;
  localparam int OCD_SRC_LO   = 6;
  localparam int OCD_FMT_HI   = 5;
  localparam int OCD_FMT_LO   = 4;
  localparam int OCD_MA_HI    = 3;
  localparam int OCD_MA_LO    = 2;
  localparam int OCD_MB_HI    = 1;
  localparam int OCD_MB_LO    = 0;
  localparam logic [1:0] OCD_SRC_RST = 2'h0;
  localparam logic [1:0] OCD_FMT_RST = 2'h1;
  localparam logic [1:0] OCD_MA_RST  = 2'h2;
  localparam logic [1:0] OCD_MB_RST  = 2'h0;
  localparam int OCD_DBL_BIT = 0;

  typedef enum logic [1:0] {
    OCD_SRC_SYNTH1 = 2'h0,
    OCD_SRC_SYNTH2 = 2'h1,
    OCD_SRC_PRIREF = 2'h2,
    OCD_SRC_SECREF = 2'h3
  } ocd_src_t;

  typedef enum logic [1:0] {
    OCD_FMT_OFF  = 2'h0,
    OCD_FMT_AC   = 2'h1,
    OCD_FMT_HCSL = 2'h2,
    OCD_FMT_CMOS = 2'h3
  } ocd_fmt_t;

  // divider in effect only on a synthesizer source
  function automatic logic ocd_is_synth(input logic [1:0] src);
    return (src == OCD_SRC_SYNTH1) || (src == OCD_SRC_SYNTH2);
  endfunction
endpackage

/* core/ocd_divider.sv */
// clock-enable divider: pulse every ratio input clocks, or every clock when bypassed
module ocd_divider
  import ocd_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and control
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  // source tick and divider setting
  input  wire logic             tick_in,
  input  wire logic             bypass_in,
  input  wire logic [WIDTH-1:0] code_in,
  // divided tick
  output logic                  tick_out
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             tick;
  } ocd_div_state_t;

  ocd_div_state_t s_q;
  ocd_div_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (tick_in) begin
      if (bypass_in || code_in == '0) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      // code n divides by n+1: count 0..n
      end else if (s_q.cnt >= code_in) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;
endmodule

/* dv/ocd_assertions.sv */
// checker: bus and channel 6 output relations of the output channel block
module ocd_checker
  import ocd_pkg::*;
(
  // clock, reset and bus
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        ce_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // channel 6 outputs
  input wire logic        ch6_p_oe_n_out,
  input wire logic        ch6_n_oe_n_out,
  input wire logic [1:0]  ch6_format_out,
  input wire logic [1:0]  ch6_tail_sel_out,
  input wire logic [1:0]  ch6_hcsl_load_out,
  input wire logic        ch6_div_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc;
  logic wctl;
  logic mapped;
  assign acc    = psel_in && penable_in;
  assign wctl   = acc && pwrite_in && pstrb_in[0] && ce_in && paddr_in == OCD_ADDR_CH6_CTL;
  assign mapped = paddr_in inside {OCD_ADDR_CH5_DIV, OCD_ADDR_CH6_CTL, OCD_ADDR_REF_CTL, OCD_ADDR_STATUS};
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_ready_now: assert property (acc |-> pready_out)
    else $error("access not answered");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr_out)
    else $error("unmapped access without error");
  a_upper_zero: assert property (acc |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  a_fmt_follow: assert property (wctl |=> ch6_format_out == $past(pwdata_in[5:4]))
    else $error("format not taken");
  a_mode_a_follow: assert property (wctl |=> ch6_tail_sel_out == $past(pwdata_in[3:2]))
    else $error("mode a not taken");
  a_load_decode: assert property (wctl |=> ch6_hcsl_load_out ==
    (ch6_format_out == OCD_FMT_HCSL ? $past(pwdata_in[1:0]) : 2'h0)) else $error("load wrong");
  a_ref_no_div: assert property (wctl && pwdata_in[7] |=> !ch6_div_active_out)
    else $error("divider active on reference");
  a_off_tristate: assert property (ch6_format_out == OCD_FMT_OFF |-> ch6_p_oe_n_out && ch6_n_oe_n_out)
    else $error("disabled output drives");
  a_ac_drive: assert property (ch6_format_out == OCD_FMT_AC |-> !ch6_p_oe_n_out && !ch6_n_oe_n_out)
    else $error("ac output not driving");
  c_hcsl: cover property (wctl && pwdata_in[5:4] == 2'h2);
  c_err: cover property (pslverr_out);
  c_div: cover property (ch6_div_active_out);
endmodule
bind ocd_top ocd_checker u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .ch6_p_oe_n_out(ch6_p_oe_n_out), .ch6_n_oe_n_out(ch6_n_oe_n_out), .ch6_format_out(ch6_format_out),
  .ch6_tail_sel_out(ch6_tail_sel_out), .ch6_hcsl_load_out(ch6_hcsl_load_out),
  .ch6_div_active_out(ch6_div_active_out)
);

/* dv/tb_top.sv */
// testbench: register access, channel 6 decode and divider ratios
module tb_top import ocd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 0, reset_in = 1, ce_in = 1, sclk = 0, sclk2 = 0;
  logic        psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out, r;
  logic [3:0]  pstrb_in = 4'h0;
  logic        pready_out, pslverr_out, err, prev, ch6_clk_p_out, ch6_clk_n_out;
  logic        ch6_p_oe_n_out, ch6_n_oe_n_out, ch6_div_active_out;
  logic [1:0]  ch6_format_out, ch6_tail_sel_out, ch6_hcsl_load_out;
  logic [7:0]  d;
  logic [7:0]  vals [3] = '{8'h00, 8'hff, 8'ha5};
  logic [7:0]  ctls [6] = '{8'h18, 8'h18, 8'h18, 8'h58, 8'h98, 8'hd8};
  logic [7:0]  divs [6] = '{8'h00, 8'h01, 8'h03, 8'h00, 8'h03, 8'h03};
  int          lens [6] = '{128, 256, 512, 256, 128, 256};
  int          num_errors = 0, n_compared = 0, cyc = 0, cnt;
  // refs share the synth clocks: only the period ratios tell sources apart
  ocd_top DUT (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .synth1_clk_in(sclk),
    .synth2_clk_in(sclk2), .priref_clk_in(sclk), .secref_clk_in(sclk2), .ch6_clk_p_out(ch6_clk_p_out),
    .ch6_clk_n_out(ch6_clk_n_out), .ch6_p_oe_n_out(ch6_p_oe_n_out), .ch6_n_oe_n_out(ch6_n_oe_n_out),
    .ch6_format_out(ch6_format_out), .ch6_tail_sel_out(ch6_tail_sel_out), .ch6_hcsl_load_out(ch6_hcsl_load_out),
    .ch6_div_active_out(ch6_div_active_out));
  always #2.5 clk_in = ~clk_in;
  always #20 sclk = ~sclk;
  always #40 sclk2 = ~sclk2;
  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
    @(posedge clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= wd;
    pstrb_in  <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    r   = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // counts output rises over n cycles; one edge of slack for window phase
  task automatic meas(input logic [7:0] ctl, input logic [7:0] dv, input int n);
    xfer(1'b1, OCD_ADDR_CH5_DIV, {24'h0, dv}, 4'hf);
    xfer(1'b1, OCD_ADDR_CH6_CTL, {24'h0, ctl}, 4'hf);
    repeat (100) @(posedge clk_in);
    cnt = 0;
    prev = ch6_clk_p_out;
    repeat (n) begin
      @(posedge clk_in);
      if (ch6_clk_p_out && !prev) cnt++;
      prev = ch6_clk_p_out;
    end
    ck({31'h0, cnt inside {[7:9]}}, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    xfer(1'b0, OCD_ADDR_CH5_DIV, 32'h0, 4'h0);
    ck(r, 32'h2);
    xfer(1'b0, OCD_ADDR_CH6_CTL, 32'h0, 4'h0);
    ck(r, 32'h18);
    foreach (vals[i]) begin
      xfer(1'b1, OCD_ADDR_CH5_DIV, {24'hffffff, vals[i]}, 4'hf);
      xfer(1'b0, OCD_ADDR_CH5_DIV, 32'h0, 4'h0);
      ck(r, {24'h0, vals[i]});
    end
    xfer(1'b1, OCD_ADDR_CH5_DIV, 32'h5a, 4'he);
    ce_in <= 1'b0;
    xfer(1'b1, OCD_ADDR_CH5_DIV, 32'h3c, 4'hf);
    ce_in <= 1'b1;
    xfer(1'b0, OCD_ADDR_CH5_DIV, 32'h0, 4'h0);
    ck(r, 32'ha5);
    xfer(1'b0, 12'h0fc, 32'h0, 4'h0);
    ck({r[30:0], err}, 32'h1);
    $display("register test done");
    xfer(1'b1, OCD_ADDR_CH5_DIV, 32'h3, 4'hf);
    for (int i = 0; i < 4; i++) begin
      d = {4{i[1:0]}};
      xfer(1'b1, OCD_ADDR_CH6_CTL, {24'h0, d}, 4'hf);
      #1;
      ck({26'h0, ch6_format_out, ch6_tail_sel_out, ch6_hcsl_load_out},
         {26'h0, i[1:0], i[1:0], i == 2 ? 2'h2 : 2'h0});
      ck({31'h0, ch6_div_active_out}, {31'h0, i < 2});
      ck({30'h0, ch6_p_oe_n_out, ch6_n_oe_n_out}, {30'h0, i == 0, i == 0});
      ck({31'h0, ch6_clk_p_out ^ ch6_clk_n_out}, {31'h0, i == 1 || i == 2});
      xfer(1'b0, OCD_ADDR_CH6_CTL, 32'h0, 4'h0);
      ck(r, {24'h0, d});
    end
    // cmos: p driven low with n tristate, then p true with n inverted
    xfer(1'b1, OCD_ADDR_CH6_CTL, 32'h34, 4'hf);
    #1;
    ck({29'h0, ch6_clk_p_out, ch6_p_oe_n_out, ch6_n_oe_n_out}, 32'h1);
    xfer(1'b1, OCD_ADDR_CH6_CTL, 32'h3e, 4'hf);
    #1;
    ck({30'h0, ch6_clk_p_out ^ ch6_clk_n_out, ch6_n_oe_n_out}, 32'h2);
    $display("decode test done");
    for (int k = 0; k < 6; k++) meas(ctls[k], divs[k], lens[k]);
    // doubled primary reference: ticks every 4 cycles, so 8 rises in 64
    xfer(1'b1, OCD_ADDR_REF_CTL, 32'h1, 4'hf);
    xfer(1'b0, OCD_ADDR_REF_CTL, 32'h0, 4'h0);
    ck(r, 32'h1);
    meas(8'h98, 8'h03, 64);
    xfer(1'b0, OCD_ADDR_STATUS, 32'h0, 4'h0);
    ck({30'h0, r[1:0]}, 32'h1);
    $display("divider test done");
    finish_test();
  end
endmodule
